// File: rtl/epiu_cfg.svh
// Register offsets, field positions and reset values of the pin interrupt unit
// Assumes inclusion by the top module and the bench only
`ifndef EPIU_CFG_SVH
`define EPIU_CFG_SVH
`define EPIU_OFF_SENSE 12'h000
`define EPIU_OFF_MASK 12'h004
`define EPIU_OFF_FLAGS 12'h008
`define EPIU_OFF_PCM_UP 12'h00C
`define EPIU_OFF_PCM_LO 12'h010
`define EPIU_OFF_CORE 12'h014
`define EPIU_OFF_ACK 12'h018
`define EPIU_OFF_IMASK 12'h01C
`define EPIU_BIT_DED 0
`define EPIU_BIT_LO 4
`define EPIU_BIT_UP 5
`define EPIU_BIT_GIE 0
`define EPIU_RST_REG 8'h00
`endif

// File: rtl/epiu_pkg.sv
// Types of the pin interrupt unit
// Assumes epiu_cfg.svh is on the include path
package epiu_pkg;
   typedef enum logic [1:0] {
      EPIU_SENSE_LOW = 2'b00,
      EPIU_SENSE_ANY = 2'b01,
      EPIU_SENSE_FALL = 2'b10,
      EPIU_SENSE_RISE = 2'b11
   } epiu_sense_type;
   typedef enum logic [1:0] {
      EPIU_VEC_NONE = 2'b00,
      EPIU_VEC_DED = 2'b01,
      EPIU_VEC_LO = 2'b10,
      EPIU_VEC_UP = 2'b11
   } epiu_vec_type;
endpackage : epiu_pkg

// File: rtl/epiu_top.sv
// External pin and pin-change interrupt unit with an APB register slave
// Assumes a single 100 MHz clock; pins are taken as synchronous inputs
//
// How it works
// - Sense bits select low level, any change, falling or rising edge.
// - Low level with pin enabled keeps the request raised while low.
// - Edges use the clock; low level is seen combinationally for wake-up.
// - Pin-change wake term is formed without the clock, then registered to wake_o.
// - Upper group fires on enabled pins 15..8, lower on pins 7..0.
// - Pin activity triggers regardless of the pin direction.
// - Dedicated pin is sampled first; pulses over one clock are caught.
// - A wake level gone before start-up gives no interrupt.
// - Dedicated vector needs mask bit 0 and the global flag; irq_o needs a set flag with its imask bit (0, 4 or 5), not the global flag.
// - Group enables at mask bits 5 and 4, gated by global flag.
// - Upper pin-change mask bits enable inputs 15 to 8.
// - Events set flag bits 5, 4 and 0.
// - Flags clear on vector entry or on a written one.
// - Dedicated flag reads zero while level sensing.
// - Flag, enable and global flag together vector the core.
// - Lower pin-change mask bits enable inputs 7 to 0.
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "epiu_cfg.svh"
module epiu_top #(
   parameter int PINS = 16
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic dedicated_irq_pin_i,
   input wire logic [PINS-1:0] pin_change_inputs_i,
   output logic [1:0] vector_o,
   output logic vector_valid_o,
   output logic irq_o,
   output logic wake_o
);
   import epiu_pkg::*;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [7:0] sense_q, sense_d;
   logic [7:0] mask_q, mask_d;
   logic [7:0] flags_q, flags_d;
   logic [7:0] pcm_up_q, pcm_up_d;
   logic [7:0] pcm_lo_q, pcm_lo_d;
   logic [7:0] imask_q, imask_d;
   logic gie_q, gie_d;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;
   logic ded_s_q, ded_s_d;
   logic ded_p_q, ded_p_d;
   logic [PINS-1:0] pc_lat_q, pc_lat_d;
   logic [PINS-1:0] pc_syn_q, pc_syn_d;
   logic [PINS-1:0] pc_prev_q, pc_prev_d;
   logic [1:0] vec_q, vec_d;
   logic vecv_q, vecv_d;
   logic irq_q, irq_d;
   logic wake_q, wake_d;

   epiu_sense_type sense;
   logic wr, rd, ded_ev, lo_ev, up_ev, level_mode, ded_level_req;
   logic [7:0] ack, w1c, set_bits, flag_view, pend;
   logic [PINS-1:0] pc_toggle;

   function automatic logic addr_is(input logic [11:0] a,
                                    input logic [11:0] off);
      addr_is = (a == off);
   endfunction : addr_is

   // Unmapped offsets answer with an error in either direction
   function automatic logic addr_known(input logic [11:0] a);
      addr_known = 1'b0;
      if (a[1:0] == 2'b00 && a <= `EPIU_OFF_IMASK) begin
         addr_known = 1'b1;
      end
   endfunction : addr_known

   assign sense = epiu_sense_type'(sense_q[1:0]);
   // Writes land on the edge that completes the transfer, reads one ahead
   assign wr = psel_i && penable_i && pwrite_i && pready_q;
   assign rd = psel_i && penable_i && !pwrite_i && !pready_q;
   assign level_mode = (sense == EPIU_SENSE_LOW);

   // ----------------------------------------------------------------
   // Event detection
   // ----------------------------------------------------------------
   always_comb begin
      ded_s_d = dedicated_irq_pin_i;
      ded_p_d = ded_s_q;
      pc_lat_d = pin_change_inputs_i;
      pc_syn_d = pc_lat_q;
      pc_prev_d = pc_syn_q;
      pc_toggle = pc_syn_q ^ pc_prev_q;
      lo_ev = |(pc_toggle[7:0] & pcm_lo_q);
      up_ev = |(pc_toggle[15:8] & pcm_up_q);
      ded_ev = 1'b0;
      case (sense)
         EPIU_SENSE_ANY: ded_ev = ded_s_q ^ ded_p_q;
         EPIU_SENSE_FALL: ded_ev = ded_p_q && !ded_s_q;
         EPIU_SENSE_RISE: ded_ev = !ded_p_q && ded_s_q;
         default: ded_ev = 1'b0;
      endcase
      // Level request follows the sampled pin, so a vanished level is
      // no request
      ded_level_req = level_mode && !ded_s_q;
      // Asynchronous wake terms, registered only for the output
      wake_d = (level_mode && mask_q[`EPIU_BIT_DED]
                && !dedicated_irq_pin_i)
               || (mask_q[`EPIU_BIT_LO] && (|(pcm_lo_q
                   & (pin_change_inputs_i[7:0] ^ pc_syn_q[7:0]))))
               || (mask_q[`EPIU_BIT_UP] && (|(pcm_up_q
                   & (pin_change_inputs_i[15:8] ^ pc_syn_q[15:8]))));
   end

   // ----------------------------------------------------------------
   // Flags, service and register bus
   // ----------------------------------------------------------------
   always_comb begin
      sense_d = sense_q;
      mask_d = mask_q;
      pcm_up_d = pcm_up_q;
      pcm_lo_d = pcm_lo_q;
      imask_d = imask_q;
      gie_d = gie_q;
      prdata_d = prdata_q;
      pslverr_d = psel_i && penable_i && !pready_q && !addr_known(paddr_i);
      pready_d = psel_i && penable_i && !pready_q;
      ack = 8'h00;
      w1c = 8'h00;
      if (wr) begin
         if (addr_is(paddr_i, `EPIU_OFF_SENSE)) begin
            sense_d = {6'h00, pwdata_i[1:0]};
         end else if (addr_is(paddr_i, `EPIU_OFF_MASK)) begin
            mask_d = pwdata_i[7:0] & 8'h31;
         end else if (addr_is(paddr_i, `EPIU_OFF_FLAGS)) begin
            w1c = pwdata_i[7:0];
         end else if (addr_is(paddr_i, `EPIU_OFF_PCM_UP)) begin
            pcm_up_d = pwdata_i[7:0];
         end else if (addr_is(paddr_i, `EPIU_OFF_PCM_LO)) begin
            pcm_lo_d = pwdata_i[7:0];
         end else if (addr_is(paddr_i, `EPIU_OFF_CORE)) begin
            gie_d = pwdata_i[`EPIU_BIT_GIE];
         end else if (addr_is(paddr_i, `EPIU_OFF_ACK)) begin
            ack = pwdata_i[7:0];
         end else if (addr_is(paddr_i, `EPIU_OFF_IMASK)) begin
            imask_d = pwdata_i[7:0] & 8'h31;
         end
      end
      // Flags set regardless of the global flag; set beats clear
      set_bits = 8'h00;
      set_bits[`EPIU_BIT_DED] = ded_ev;
      set_bits[`EPIU_BIT_LO] = lo_ev;
      set_bits[`EPIU_BIT_UP] = up_ev;
      flags_d = ((flags_q & ~(w1c | ack)) | set_bits) & 8'h31;
      if (level_mode) begin
         flags_d[`EPIU_BIT_DED] = 1'b0;
      end
      flag_view = flags_q;
      flag_view[`EPIU_BIT_DED] = flags_q[`EPIU_BIT_DED] && !level_mode;
      pend = flag_view & mask_q;
      pend[`EPIU_BIT_DED] = (flag_view[`EPIU_BIT_DED] || ded_level_req)
                            && mask_q[`EPIU_BIT_DED];
      // Fixed priority: dedicated pin, then lower, then upper
      vecv_d = gie_q && (|pend);
      if (pend[`EPIU_BIT_DED]) begin
         vec_d = EPIU_VEC_DED;
      end else if (pend[`EPIU_BIT_LO]) begin
         vec_d = EPIU_VEC_LO;
      end else if (pend[`EPIU_BIT_UP]) begin
         vec_d = EPIU_VEC_UP;
      end else begin
         vec_d = EPIU_VEC_NONE;
      end
      irq_d = |(flag_view & imask_q);
      if (rd) begin
         if (addr_is(paddr_i, `EPIU_OFF_SENSE)) begin
            prdata_d = {24'h000000, sense_q};
         end else if (addr_is(paddr_i, `EPIU_OFF_MASK)) begin
            prdata_d = {24'h000000, mask_q};
         end else if (addr_is(paddr_i, `EPIU_OFF_FLAGS)) begin
            prdata_d = {24'h000000, flag_view};
         end else if (addr_is(paddr_i, `EPIU_OFF_PCM_UP)) begin
            prdata_d = {24'h000000, pcm_up_q};
         end else if (addr_is(paddr_i, `EPIU_OFF_PCM_LO)) begin
            prdata_d = {24'h000000, pcm_lo_q};
         end else if (addr_is(paddr_i, `EPIU_OFF_CORE)) begin
            prdata_d = {31'h00000000, gie_q};
         end else if (addr_is(paddr_i, `EPIU_OFF_IMASK)) begin
            prdata_d = {24'h000000, imask_q};
         end else if (addr_is(paddr_i, `EPIU_OFF_ACK)) begin
            prdata_d = 32'h00000000;
         end else begin
            prdata_d = 32'h00000000;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         sense_q <= `EPIU_RST_REG;
         mask_q <= `EPIU_RST_REG;
         flags_q <= `EPIU_RST_REG;
         pcm_up_q <= `EPIU_RST_REG;
         pcm_lo_q <= `EPIU_RST_REG;
         imask_q <= `EPIU_RST_REG;
         gie_q <= 1'b0;
         prdata_q <= 32'h00000000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         ded_s_q <= 1'b1;
         ded_p_q <= 1'b1;
         pc_lat_q <= '0;
         pc_syn_q <= '0;
         pc_prev_q <= '0;
         vec_q <= 2'b00;
         vecv_q <= 1'b0;
         irq_q <= 1'b0;
         wake_q <= 1'b0;
      end else begin
         sense_q <= sense_d;
         mask_q <= mask_d;
         flags_q <= flags_d;
         pcm_up_q <= pcm_up_d;
         pcm_lo_q <= pcm_lo_d;
         imask_q <= imask_d;
         gie_q <= gie_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         ded_s_q <= ded_s_d;
         ded_p_q <= ded_p_d;
         pc_lat_q <= pc_lat_d;
         pc_syn_q <= pc_syn_d;
         pc_prev_q <= pc_prev_d;
         vec_q <= vec_d;
         vecv_q <= vecv_d;
         irq_q <= irq_d;
         wake_q <= wake_d;
      end
   end

   assign prdata_o = prdata_q;
   assign pready_o = pready_q;
   assign pslverr_o = pslverr_q;
   assign vector_o = vec_q;
   assign vector_valid_o = vecv_q;
   assign irq_o = irq_q;
   assign wake_o = wake_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   fall_sets_flag_a: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (sense == EPIU_SENSE_FALL && ded_p_q && !ded_s_q && !wr)
      |=> flags_q[0])
      else $error("falling edge did not set flag");
   level_holds_a: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (level_mode && mask_q[0] && gie_q && !ded_s_q && !wr)
      |=> vecv_q && vec_q == EPIU_VEC_DED)
      else $error("low level not requesting");
   pulse_caught_a: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (sense == EPIU_SENSE_ANY && $changed(dedicated_irq_pin_i)
       && !wr && !$past(wr)) |-> ##2 flags_q[0])
      else $error("toggle pulse missed");
   upper_group_a: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (|(pc_toggle[15:8] & pcm_up_q)) |=> flags_q[5])
      else $error("upper group flag not set");
   lower_group_a: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (|(pc_toggle[7:0] & pcm_lo_q)) |=> flags_q[4])
      else $error("lower group flag not set");
   gie_gates_a: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      !gie_q |=> !vecv_q)
      else $error("vector without global flag");
   level_flag_zero_a: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      level_mode |=> !flags_q[0] || !level_mode)
      else $error("flag set in level mode");
   ack_clears_a: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (wr && addr_is(paddr_i, `EPIU_OFF_ACK) && pwdata_i[5] && !up_ev)
      |=> !flags_q[5])
      else $error("vector entry did not clear flag");
   group_mask_a: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (!mask_q[5] && !mask_q[4] && !mask_q[0]) |=> !vecv_q)
      else $error("vector with all enables off");
   rise_sets_flag_a: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (sense == EPIU_SENSE_RISE && !ded_p_q && ded_s_q) |=> flags_q[0])
      else $error("rising edge did not set flag");
   fall_only_a: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (sense == EPIU_SENSE_FALL && !flags_q[0] && !(ded_p_q && !ded_s_q))
      |=> !flags_q[0])
      else $error("flag set without falling edge");
   w1c_clears_a: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (wr && addr_is(paddr_i, `EPIU_OFF_FLAGS) && pwdata_i[0] && !ded_ev)
      |=> !flags_q[0])
      else $error("written one did not clear flag");
   upper_mask_off_a: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (!(|(pc_toggle[15:8] & pcm_up_q)) && !flags_q[5]) |=> !flags_q[5])
      else $error("masked upper input set flag");
   lower_mask_off_a: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (!(|(pc_toggle[7:0] & pcm_lo_q)) && !flags_q[4]) |=> !flags_q[4])
      else $error("masked lower input set flag");
   lower_vector_a: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (gie_q && flags_q[4] && mask_q[4] && !mask_q[0])
      |=> vecv_q && vec_q == EPIU_VEC_LO)
      else $error("lower group not vectored");
   ded_enable_a: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      !mask_q[0] |=> vec_q != EPIU_VEC_DED)
      else $error("dedicated vector while disabled");
   pc_wake_a: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (mask_q[5] && (|(pcm_up_q
       & (pin_change_inputs_i[15:8] ^ pc_syn_q[15:8])))) |=> wake_q)
      else $error("pin change gave no wake");
   level_wake_a: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (level_mode && mask_q[0] && !dedicated_irq_pin_i) |=> wake_q)
      else $error("low level gave no wake");
   level_gone_a: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (level_mode && ded_s_q) |=> vec_q != EPIU_VEC_DED)
      else $error("vanished level still vectored");
endmodule : epiu_top

// File: tb/epiu_pins.sv
// Model of the external signals on the interrupt-capable pins
// Assumes requests change just after a rising edge of clk_i
`timescale 1ns/1ps
module epiu_pins (
   input wire logic clk_i,
   input wire logic ded_set_i,
   input wire logic [15:0] pc_set_i,
   output logic dedicated_irq_pin_o,
   output logic [15:0] pin_change_inputs_o
);
   initial begin
      dedicated_irq_pin_o = 1'b1;
      pin_change_inputs_o = 16'h0000;
   end
   // Every level is held for whole clock periods, low levels included
   always @(posedge clk_i) begin
      dedicated_irq_pin_o <= ded_set_i;
      pin_change_inputs_o <= pc_set_i;
   end
endmodule : epiu_pins

// File: tb/external_pin_interrupt_unit_bench.sv
// Self-checking bench of the pin interrupt unit over APB
// Assumes epiu_pkg compiled first and epiu_cfg.svh on the include path
`timescale 1ns/1ps
`include "epiu_cfg.svh"
module external_pin_interrupt_unit_bench;
   import epiu_pkg::*;
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0;
   logic [31:0] prdata_o;
   logic pready_o;
   logic pslverr_o;
   logic ded_set = 1'b1;
   logic [15:0] pc_set = 16'h0000;
   logic pin_w;
   logic [15:0] pc_w;
   logic [1:0] vector_o;
   logic vector_valid_o;
   logic irq_o;
   logic wake_o;
   logic [31:0] rd;
   logic er;
   int n_errors = 0;
   int checked = 0;
   always #5 clk_i = ~clk_i;
   epiu_pins pins_u (.clk_i(clk_i), .ded_set_i(ded_set), .pc_set_i(pc_set),
      .dedicated_irq_pin_o(pin_w), .pin_change_inputs_o(pc_w));
   epiu_top #(.PINS(16)) dut_u (.clk_i(clk_i), .nrst_i(nrst_i),
      .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
      .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o),
      .dedicated_irq_pin_i(pin_w), .pin_change_inputs_i(pc_w),
      .vector_o(vector_o), .vector_valid_o(vector_valid_o), .irq_o(irq_o),
      .wake_o(wake_o));
   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic test_done;
      $display("errors=%0d checks=%0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : test_done
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask : cyc
   // Entered just after a rising edge; leaves one idle edge behind it
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int k;
      k = 0;
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge clk_i);
         k++;
      end while (pready_o !== 1'b1 && k < 50);
      rd = prdata_o;
      er = pslverr_o;
      if (k >= 50) begin
         n_errors++;
         test_done();
      end
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clk_i);
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rd, exp);
   endtask : rdchk
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
      for (int a = 0; a < 32; a += 4) rdchk(12'(a), 32'h0);
      apb(1'b0, 12'h020, 32'h0);
      check(32'(er), 32'h1);
      check(rd, 32'h0);
   endtask : t_reset
   task automatic t_edges;
      wr(`EPIU_OFF_MASK, 32'h31);
      for (int m = 1; m < 4; m++) begin
         wr(`EPIU_OFF_SENSE, 32'(m));
         wr(`EPIU_OFF_FLAGS, 32'h1);
         ded_set <= 1'b0;
         cyc(4);
         rdchk(`EPIU_OFF_FLAGS, 32'(m != 3));
         check(32'(vector_valid_o), 32'h0);
         wr(`EPIU_OFF_FLAGS, 32'h1);
         ded_set <= 1'b1;
         cyc(4);
         rdchk(`EPIU_OFF_FLAGS, 32'(m != 2));
         wr(`EPIU_OFF_FLAGS, 32'h1);
      end
   endtask : t_edges
   task automatic t_level;
      wr(`EPIU_OFF_SENSE, 32'h0);
      wr(`EPIU_OFF_CORE, 32'h1);
      ded_set <= 1'b0;
      cyc(4);
      rdchk(`EPIU_OFF_FLAGS, 32'h0);
      check(32'(vector_valid_o), 32'h1);
      check(32'(vector_o), 32'(EPIU_VEC_DED));
      check(32'(wake_o), 32'h1);
      wr(`EPIU_OFF_MASK, 32'h30);
      cyc(2);
      check(32'(vector_valid_o), 32'h0);
      wr(`EPIU_OFF_MASK, 32'h31);
      ded_set <= 1'b1;
      cyc(4);
      check(32'(vector_valid_o), 32'h0);
      wr(`EPIU_OFF_CORE, 32'h0);
   endtask : t_level
   task automatic t_groups;
      wr(`EPIU_OFF_SENSE, 32'h3);
      wr(`EPIU_OFF_PCM_UP, 32'h01);
      wr(`EPIU_OFF_PCM_LO, 32'h80);
      wr(`EPIU_OFF_MASK, 32'h30);
      pc_set <= 16'h0200;
      cyc(5);
      rdchk(`EPIU_OFF_FLAGS, 32'h0);
      pc_set <= 16'h0300;
      cyc(5);
      rdchk(`EPIU_OFF_FLAGS, 32'h20);
      pc_set <= 16'h0340;
      cyc(5);
      rdchk(`EPIU_OFF_FLAGS, 32'h20);
      pc_set <= 16'h03C0;
      cyc(5);
      rdchk(`EPIU_OFF_FLAGS, 32'h30);
      wr(`EPIU_OFF_IMASK, 32'h10);
      wr(`EPIU_OFF_CORE, 32'h1);
      cyc(3);
      check(32'(irq_o), 32'h1);
      check(32'(vector_o), 32'(EPIU_VEC_LO));
      wr(`EPIU_OFF_MASK, 32'h20);
      cyc(3);
      check(32'(vector_o), 32'(EPIU_VEC_UP));
      wr(`EPIU_OFF_ACK, 32'h10);
      rdchk(`EPIU_OFF_FLAGS, 32'h20);
      check(32'(irq_o), 32'h0);
      wr(`EPIU_OFF_FLAGS, 32'h20);
      cyc(3);
      rdchk(`EPIU_OFF_FLAGS, 32'h0);
      check(32'(vector_valid_o), 32'h0);
   endtask : t_groups
   initial begin
      cyc(8);
      nrst_i <= 1'b1;
      t_reset();
      t_edges();
      t_level();
      t_groups();
      test_done();
   end
endmodule : external_pin_interrupt_unit_bench
